// File: rtl/cfs_pkg.sv
// Constants and carrier types for the CAN fault supervisor
package cfs_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int BUS_DOM_LIMIT_US = 700;
   localparam int TX_DOM_LIMIT_US = 700;
   localparam int BUS_DOM_CYCLES = BUS_DOM_LIMIT_US * 1000 / CLK_PERIOD_NS;
   localparam int TX_DOM_CYCLES = TX_DOM_LIMIT_US * 1000 / CLK_PERIOD_NS;
   localparam int TMR_W = 17;
   localparam int ECHO_FAIL_LIMIT = 4;
   localparam int ECHO_W = 3;
   localparam int ECHO_WAIT_CYCLES = 100;
   localparam logic LVL_DOM = 1'b0;
   localparam logic LVL_REC = 1'b1;

   // ----------------------------------------
   // Status carrier
   // ----------------------------------------
   typedef struct packed {
      logic fault_any;
      logic bus_dom;
      logic tx_dom;
      logic echo_fail;
   } cfs_status_t;

   typedef struct packed {
      logic bus_dom;
      logic tx_dom;
      logic echo_fail;
   } cfs_clear_t;

   localparam cfs_status_t STATUS_RST = '{default: 1'b0};
endpackage

// File: rtl/cfs_dom_timer.sv
// Dominant level timeout detector
`timescale 1ns/1ns
`default_nettype none
module cfs_dom_timer #(
   parameter int LIMIT = 70000
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic level_i,
   output logic expired_o
);
   import cfs_pkg::*;
   logic [TMR_W-1:0] cnt_r;
   logic [TMR_W-1:0] cnt_nxt;
   logic exp_nxt;

   always_comb begin
      cnt_nxt = '0;
      exp_nxt = 1'b0;
      if (level_i == LVL_DOM) begin
         // Saturate so one long dominant stretch gives one pulse
         if (cnt_r < TMR_W'(LIMIT)) begin
            cnt_nxt = cnt_r + TMR_W'(1);
         end else begin
            cnt_nxt = cnt_r;
         end
         exp_nxt = (cnt_r == TMR_W'(LIMIT - 1));
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cnt_r <= '0;
         expired_o <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         expired_o <= exp_nxt;
      end
   end
endmodule
`default_nettype wire

// File: rtl/cfs_supervisor.sv
// CAN transceiver fault supervisor
`timescale 1ns/1ns
`default_nettype none
module cfs_supervisor (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic dev_reset_done_i,
   input wire logic fault_handling_disable_i,
   input wire logic tx_i,
   input wire logic bus_rx_i,
   input wire cfs_pkg::cfs_clear_t clear_i,
   output logic drv_tx_o,
   output logic rx_o,
   output logic tx_enabled_o,
   output cfs_pkg::cfs_status_t status_o
);
   import cfs_pkg::*;

   // ----------------------------------------
   // Timeouts
   // ----------------------------------------
   logic bus_dom_exp;
   logic tx_dom_exp;

   cfs_dom_timer #(.LIMIT(BUS_DOM_CYCLES)) u_bus_tmr (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .level_i(bus_rx_i),
      .expired_o(bus_dom_exp)
   );

   cfs_dom_timer #(.LIMIT(TX_DOM_CYCLES)) u_tx_tmr (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .level_i(tx_i),
      .expired_o(tx_dom_exp)
   );

   // ----------------------------------------
   // Echo supervisor
   // ----------------------------------------
   typedef enum logic [1:0] {
      CFS_IDLE = 2'b01,
      CFS_WAIT = 2'b10
   } cfs_echo_t;

   cfs_echo_t st_r;
   cfs_echo_t st_nxt;
   logic tx_prev_r;
   logic tx_prev_nxt;
   logic [ECHO_W-1:0] fail_r;
   logic [ECHO_W-1:0] fail_nxt;
   logic [7:0] wait_r;
   logic [7:0] wait_nxt;
   logic armed_r;
   logic armed_nxt;
   logic tx_fall;
   logic echo_start;
   logic echo_seen;
   logic echo_timeout;
   logic echo_last;
   logic echo_fault;

   // ----------------------------------------
   // Echo events
   // ----------------------------------------
   always_comb begin
      tx_fall = (tx_prev_r == LVL_REC) && (tx_i == LVL_DOM);
      // Only an edge we actually drove can be checked for echo
      echo_start = tx_fall && (drv_tx_o == LVL_REC) && armed_r
         && !status_o.echo_fail && !status_o.tx_dom;
      echo_seen = (bus_rx_i == LVL_DOM);
      echo_timeout = (wait_r == 8'(ECHO_WAIT_CYCLES - 1));
      echo_last = (fail_r == ECHO_W'(ECHO_FAIL_LIMIT - 1));
   end

   // ----------------------------------------
   // Echo state machine
   // ----------------------------------------
   always_comb begin
      st_nxt = st_r;
      fail_nxt = fail_r;
      wait_nxt = wait_r;
      echo_fault = 1'b0;
      tx_prev_nxt = tx_i;
      case (st_r)
         CFS_IDLE: begin
            if (echo_start) begin
               st_nxt = CFS_WAIT;
               wait_nxt = '0;
            end
         end
         CFS_WAIT: begin
            if (echo_seen) begin
               // Failures must be back to back; any echo restarts the count
               st_nxt = CFS_IDLE;
               fail_nxt = '0;
            end else if (echo_timeout) begin
               st_nxt = CFS_IDLE;
               if (echo_last) begin
                  echo_fault = 1'b1;
                  fail_nxt = '0;
               end else begin
                  fail_nxt = fail_r + ECHO_W'(1);
               end
            end else begin
               wait_nxt = wait_r + 8'h01;
            end
         end
         default: begin
            st_nxt = CFS_IDLE;
         end
      endcase
      if (fault_handling_disable_i) begin
         st_nxt = CFS_IDLE;
         fail_nxt = '0;
         echo_fault = 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         st_r <= CFS_IDLE;
         fail_r <= '0;
         wait_r <= '0;
         tx_prev_r <= LVL_REC;
      end else begin
         st_r <= st_nxt;
         fail_r <= fail_nxt;
         wait_r <= wait_nxt;
         tx_prev_r <= tx_prev_nxt;
      end
   end

   // ----------------------------------------
   // Arming
   // ----------------------------------------
   // Remembered, so a one-cycle reset pulse is enough
   always_comb begin
      armed_nxt = armed_r | dev_reset_done_i;
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         armed_r <= 1'b0;
      end else begin
         armed_r <= armed_nxt;
      end
   end

   // ----------------------------------------
   // Status
   // ----------------------------------------
   cfs_status_t status_nxt;

   always_comb begin
      status_nxt = status_o;
      // Set beats a same-cycle clear so no event is lost
      if (clear_i.bus_dom) status_nxt.bus_dom = 1'b0;
      if (clear_i.tx_dom) status_nxt.tx_dom = 1'b0;
      if (clear_i.echo_fail) status_nxt.echo_fail = 1'b0;
      if (!fault_handling_disable_i) begin
         if (bus_dom_exp) status_nxt.bus_dom = 1'b1;
         if (tx_dom_exp) status_nxt.tx_dom = 1'b1;
         if (echo_fault) status_nxt.echo_fail = 1'b1;
      end
      status_nxt.fault_any = status_nxt.bus_dom | status_nxt.tx_dom | status_nxt.echo_fail;
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         status_o <= STATUS_RST;
      end else begin
         status_o <= status_nxt;
      end
   end

   // ----------------------------------------
   // Transmit gate
   // ----------------------------------------
   logic drv_nxt;
   logic gate_open;

   always_comb begin
      gate_open = armed_nxt && !status_nxt.echo_fail && !status_nxt.tx_dom;
      // Bus dominant flag deliberately not in this gate
      drv_nxt = LVL_REC;
      if (gate_open) begin
         drv_nxt = tx_i;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         drv_tx_o <= LVL_REC;
      end else begin
         drv_tx_o <= drv_nxt;
      end
   end

   // ----------------------------------------
   // Receive copy
   // ----------------------------------------
   logic rx_nxt;

   always_comb begin
      rx_nxt = bus_rx_i;
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         rx_o <= LVL_REC;
      end else begin
         rx_o <= rx_nxt;
      end
   end

   // ----------------------------------------
   // Enable view
   // ----------------------------------------
   assign tx_enabled_o = armed_r && !status_o.echo_fail && !status_o.tx_dom;
endmodule
`default_nettype wire

// File: testbench/cfs_supervisor_assertions.sv
// Assertion checker for the CAN fault supervisor
`timescale 1ns/1ns
`default_nettype none
module cfs_supervisor_chk (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic fault_handling_disable_i,
   input wire logic tx_i,
   input wire cfs_pkg::cfs_clear_t clear_i,
   input wire logic drv_tx_o,
   input wire logic tx_enabled_o,
   input wire cfs_pkg::cfs_status_t status_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   a_tx_gated: assert property (!tx_enabled_o && !$past(tx_enabled_o) |-> drv_tx_o)
      else $error("drive not recessive");
   a_tx_follow: assert property (tx_enabled_o && $past(tx_enabled_o) |-> drv_tx_o == $past(tx_i))
      else $error("drive lost tx");
   a_bus_report: assert property ($rose(status_o.bus_dom) && $past(tx_enabled_o)
      && !status_o.tx_dom && !status_o.echo_fail |-> tx_enabled_o) else $error("bus dom gated");
   a_fault_any: assert property (status_o[2:0] != 3'h0 |-> status_o.fault_any)
      else $error("no common flag");
   a_bus_sticky: assert property (status_o.bus_dom && !clear_i.bus_dom |=> status_o.bus_dom)
      else $error("bus dom lost");
   a_echo_sticky: assert property (status_o.echo_fail && !clear_i.echo_fail |=> status_o.echo_fail)
      else $error("echo lost");
   a_echo_off: assert property (status_o.echo_fail |-> !tx_enabled_o)
      else $error("echo tx on");
   a_txdom_off: assert property (status_o.tx_dom |-> !tx_enabled_o)
      else $error("tx dom tx on");
   a_no_set: assert property (fault_handling_disable_i && !status_o.echo_fail |=>
      !status_o.echo_fail) else $error("set while off");
   c_echo: cover property ($rose(status_o.echo_fail));
   c_bus: cover property ($rose(status_o.bus_dom));
   c_tx: cover property ($rose(status_o.tx_dom));
endmodule
bind cfs_supervisor cfs_supervisor_chk i_chk (.clk_i(clk_i), .reset_i(reset_i),
   .fault_handling_disable_i(fault_handling_disable_i), .tx_i(tx_i), .clear_i(clear_i),
   .drv_tx_o(drv_tx_o), .tx_enabled_o(tx_enabled_o), .status_o(status_o));
`default_nettype wire

// File: testbench/cfs_far_model.sv
// Bus echo model for the supervisor's far side
`timescale 1ns/1ns
`default_nettype none
module cfs_far_model (
   input wire logic drv_tx_i,
   input wire logic stuck_i,
   input wire logic dom_i,
   output logic bus_rx_o
);
   // Stuck models a clamped receiver; dom a shorted bus
   assign bus_rx_o = dom_i ? 1'h0 : (stuck_i | drv_tx_i);
endmodule
`default_nettype wire

// File: testbench/can_transceiver_fault_supervisor_test.sv
// Testbench for the CAN fault supervisor
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
   $display("mismatch %0t value", $time); end end
module can_transceiver_fault_supervisor_test;
   import cfs_pkg::*;
   logic clk_i = 0, reset_i = 1, done = 0, dis = 0, tx = 1, stuck = 0, dom = 0;
   logic drv, en, rx, bus;
   cfs_clear_t clr = '0;
   cfs_status_t st;
   int failures = 0, n_tests = 0;
   logic [1:0] rows [4] = '{2'h0, 2'h3, 2'h0, 2'h3}; // tx beside expected drive
   cfs_supervisor i_dut (.clk_i(clk_i), .reset_i(reset_i), .dev_reset_done_i(done),
      .fault_handling_disable_i(dis), .tx_i(tx), .bus_rx_i(bus), .clear_i(clr),
      .drv_tx_o(drv), .rx_o(rx), .tx_enabled_o(en), .status_o(st));
   cfs_far_model i_far (.drv_tx_i(drv), .stuck_i(stuck), .dom_i(dom), .bus_rx_o(bus));
   initial forever #5 clk_i = ~clk_i;
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // Each pulse is longer than the echo window but far below the dominant limit
   task automatic fail_echo();
      cyc(1); tx <= 0; cyc(110); tx <= 1; cyc(1);
   endtask
   task automatic wrap_up();
      $display("tests %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      #1_000_000; failures++; wrap_up();
   end
   initial begin
      cyc(8); reset_i <= 0; tx <= 0;
      cyc(3); #1 `CHK(drv, 1'h1)
      cyc(1); done <= 1;
      foreach (rows[i]) begin cyc(1); tx <= rows[i][1]; cyc(1); #1 `CHK(drv, rows[i][0]) end
      $display("end arm");
      cyc(1); stuck <= 1;
      repeat (3) fail_echo();
      #1 `CHK(en, 1'h1)
      fail_echo(); cyc(2);
      #1 `CHK(st, 4'h9)
      `CHK(drv, 1'h1)
      cyc(1); stuck <= 0; clr <= 3'h1; cyc(1); clr <= '0; cyc(2);
      #1 `CHK({st, en}, 5'h01)
      $display("end echo");
      cyc(1); dis <= 1; stuck <= 1;
      repeat (4) fail_echo();
      cyc(2); #1 `CHK({st, en}, 5'h01)
      cyc(1); dis <= 0; stuck <= 0; dom <= 1;
      $display("end disable");
      cyc(1000); tx <= 0; cyc(69010);
      #1 `CHK({st, en, drv}, 6'h32)
      `CHK(rx, 1'h0)
      cyc(1000);
      #1 `CHK({st, en, drv}, 6'h39)
      cyc(1); dom <= 0; tx <= 1; clr <= 3'h6; cyc(1); clr <= '0; cyc(2);
      #1 `CHK({st, en}, 5'h01)
      `CHK(rx, 1'h1)
      $display("end timeouts");
      wrap_up();
   end
endmodule
`default_nettype wire
